//--- pkg/sdo_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
// Load and zero flag of one down counter
interface sdo_cnt_if #(parameter int W = 16);
  logic load;
  logic [W-1:0] value;
  logic zero;
  modport ctrl (output load, output value, input zero);
  modport cnt (input load, input value, output zero);
endinterface
`default_nettype wire

//--- pkg/sdo_pkg.sv
// Contract
// - Each step pulse stays active for the extra-step-length value plus one clock cycles.
// - After a direction output change no step pulse starts for the direction set-up count.
// - The direction output never changes while a step pulse is active; a write to config bit 5 during a pulse still flips it.
// - After a pulse ends the direction holds for a further extra-step-length plus one cycles.
// - By default the step output idles low and marks a step with a high pulse.
// - With config bit 3 set the step output idles high and marks a step with a low pulse.
// - With config bit 4 set the step output inverts once per step.
// - By default the direction output is high for negative and low for positive steps.
// - With config bit 5 cleared the direction output is high for positive steps.
package sdo_pkg;
  localparam int SDO_AW = 7;
  localparam int SDO_TW = 16;
  // Register offsets
  localparam logic [6:0] SDO_GLOBAL_CONFIG_ADDR = 7'h00;
  localparam logic [6:0] SDO_STEP_DIR_TIMING_ADDR = 7'h10;
  localparam logic [6:0] SDO_STATUS_ADDR = 7'h11;
  // Global config fields
  localparam int SDO_CFG_W = 6;
  localparam int SDO_STEP_POL_BIT = 3;
  localparam int SDO_TOGGLE_BIT = 4;
  localparam int SDO_DIR_POL_BIT = 5;
  localparam logic [5:0] SDO_CFG_RESET = 6'h20;
  // Timing register fields
  localparam int SDO_EXTRA_LSB = 0;
  localparam int SDO_SETUP_LSB = 16;
  localparam logic [31:0] SDO_TIMING_RESET = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [3:0] {
    SDO_IDLE = 4'b0001,
    SDO_SETUP = 4'b0010,
    SDO_PULSE = 4'b0100,
    SDO_HOLD = 4'b1000
  } sdo_state_t;
endpackage

//--- rtl/sdo_down_counter.sv
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter that stops at zero
module sdo_down_counter #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  sdo_cnt_if.cnt port
);
  logic [W-1:0] count;

  // Load wins over the count
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count <= '0;
    end else if (port.load) begin
      count <= port.value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign port.zero = (count == '0);
endmodule // sdo_down_counter
`default_nettype wire

//--- rtl/sdo_step_dir.sv
`timescale 1ns/10ps
`default_nettype none
// Step and direction output stage
module sdo_step_dir
  import sdo_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic STEP_REQ_IN,
  input wire logic STEP_NEG_IN,
  output logic STEP_READY_OUT,
  input wire logic [SDO_AW-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic STEP_PULSE_PIN_OUT,
  output logic DIRECTION_PIN_OUT
);
  logic [SDO_CFG_W-1:0] global_config;
  logic [31:0] step_dir_timing;
  sdo_state_t state;
  sdo_state_t next_state;
  logic pend;
  logic pend_neg;
  logic dir_neg;
  logic next_dir_neg;
  logic toggle_level;
  logic start_pulse;
  logic next_step_pin;
  logic take_req;
  logic step_inactive_pol;
  logic toggle_step;
  logic pol_dir_out;
  logic [SDO_TW-1:0] step_width_extra_cycles;
  logic [SDO_TW-1:0] dir_setup_cycles;

  sdo_cnt_if #(.W(SDO_TW)) tmr ();
  sdo_cnt_if #(.W(SDO_TW)) setup ();

  // Width timer and set-up timer
  sdo_down_counter #(.W(SDO_TW)) u_width_cnt (
    .clk_in(CORE_CLK_IN),
    .srst_in(SRST_IN),
    .port(tmr)
  );
  sdo_down_counter #(.W(SDO_TW)) u_setup_cnt (
    .clk_in(CORE_CLK_IN),
    .srst_in(SRST_IN),
    .port(setup)
  );

  // Config fields
  assign step_inactive_pol = global_config[SDO_STEP_POL_BIT];
  assign toggle_step = global_config[SDO_TOGGLE_BIT];
  assign pol_dir_out = global_config[SDO_DIR_POL_BIT];
  assign step_width_extra_cycles = step_dir_timing[SDO_EXTRA_LSB +: SDO_TW];
  assign dir_setup_cycles = step_dir_timing[SDO_SETUP_LSB +: SDO_TW];

  // Register writes
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      global_config <= SDO_CFG_RESET;
      step_dir_timing <= SDO_TIMING_RESET;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == SDO_GLOBAL_CONFIG_ADDR) begin
        global_config <= REG_WDATA_IN[SDO_CFG_W-1:0];
      end
      if (REG_ADDR_IN == SDO_STEP_DIR_TIMING_ADDR) begin
        step_dir_timing <= REG_WDATA_IN;
      end
    end
  end

  // Register reads, one cycle after the strobe
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        SDO_GLOBAL_CONFIG_ADDR: REG_RDATA_OUT <= {26'h0000000, global_config};
        SDO_STEP_DIR_TIMING_ADDR: REG_RDATA_OUT <= step_dir_timing;
        SDO_STATUS_ADDR: REG_RDATA_OUT <= {26'h0000000, pend, dir_neg, state};
        default: REG_RDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // Request slot; a blocked request waits here
  assign take_req = STEP_REQ_IN && !pend;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      pend <= 1'b0;
      pend_neg <= 1'b0;
    end else if (take_req) begin
      pend <= 1'b1;
      pend_neg <= STEP_NEG_IN;
    end else if (start_pulse) begin
      pend <= 1'b0;
    end
  end

  // Ready follows the slot
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      STEP_READY_OUT <= 1'b0;
    end else begin
      STEP_READY_OUT <= !(take_req || (pend && !start_pulse));
    end
  end

  // Sequencer decisions
  always_comb begin
    next_state = state;
    next_dir_neg = dir_neg;
    start_pulse = 1'b0;
    tmr.load = 1'b0;
    tmr.value = step_width_extra_cycles;
    setup.load = 1'b0;
    setup.value = dir_setup_cycles;
    case (state)
      SDO_IDLE: begin
        if (pend && (pend_neg != dir_neg)) begin
          next_dir_neg = pend_neg;
          setup.load = 1'b1;
          next_state = SDO_SETUP;
        end else if (pend) begin
          start_pulse = 1'b1;
        end
      end
      SDO_SETUP: begin
        if (setup.zero) begin
          start_pulse = 1'b1;
        end
      end
      SDO_PULSE: begin
        if (tmr.zero) begin
          tmr.load = 1'b1;
          next_state = SDO_HOLD;
        end
      end
      SDO_HOLD: begin
        if (tmr.zero) begin
          next_state = SDO_IDLE;
        end
      end
      default: next_state = SDO_IDLE;
    endcase
    if (start_pulse) begin
      tmr.load = 1'b1;
      next_state = SDO_PULSE;
    end
  end

  // State and logical direction
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      state <= SDO_IDLE;
      dir_neg <= 1'b0;
    end else begin
      state <= next_state;
      dir_neg <= next_dir_neg;
    end
  end

  // Toggle-mode level flips once per step; outside toggle mode it tracks the idle level
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      toggle_level <= 1'b0;
    end else if (!toggle_step) begin
      toggle_level <= step_inactive_pol; // No stray edge when toggle mode starts
    end else if (start_pulse) begin
      toggle_level <= !toggle_level;
    end
  end

  // Step pin level for the next cycle
  always_comb begin
    if (toggle_step) begin
      next_step_pin = toggle_level ^ start_pulse;
    end else if (next_state == SDO_PULSE) begin
      next_step_pin = !step_inactive_pol;
    end else begin
      next_step_pin = step_inactive_pol;
    end
  end

  // Pins straight from flops
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      STEP_PULSE_PIN_OUT <= 1'b0;
      DIRECTION_PIN_OUT <= 1'b0;
    end else begin
      STEP_PULSE_PIN_OUT <= next_step_pin;
      DIRECTION_PIN_OUT <= next_dir_neg ~^ global_config[SDO_DIR_POL_BIT];
    end
  end

  // Helper: cycles since last logical direction change, saturating
  logic [SDO_TW:0] since_dir;
  logic [SDO_TW:0] pulse_len;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      since_dir <= '1;
      pulse_len <= '0;
    end else begin
      if (dir_neg != next_dir_neg) begin
        since_dir <= '0;
      end else if (since_dir != '1) begin
        since_dir <= since_dir + 1'b1;
      end
      if (state == SDO_PULSE) begin
        pulse_len <= pulse_len + 1'b1;
      end else begin
        pulse_len <= '0;
      end
    end
  end

  // Helper: cycles since the last pulse cycle, saturating
  logic [SDO_TW:0] since_end;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      since_end <= '1;
    end else if (state == SDO_PULSE) begin
      since_end <= '0;
    end else if (since_end != '1) begin
      since_end <= since_end + 1'b1;
    end
  end

  // Direction about to move
  sequence dir_move_s;
    (dir_neg != next_dir_neg);
  endsequence

  // Pulse ends when the sequencer enters hold
  sequence pulse_end_s;
    (state == SDO_PULSE) ##1 (state == SDO_HOLD);
  endsequence

  sequence dir_change_s;
    $changed(dir_neg);
  endsequence

  pulse_width_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    pulse_end_s |-> $past(pulse_len, 1) == {1'b0, step_width_extra_cycles})
    else $error("step pulse width differs from extra plus one");

  setup_gap_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (start_pulse && state == SDO_SETUP) |-> since_dir >= {1'b0, dir_setup_cycles})
    else $error("step started inside direction set-up time");

  dir_in_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (state == SDO_PULSE) |-> !$changed(dir_neg))
    else $error("direction moved during a step pulse");

  dir_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    dir_change_s |-> $past(state, 1) == SDO_IDLE)
    else $error("direction moved inside the hold window");

  step_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    ($past(state, 1) != SDO_PULSE && !$past(toggle_step, 1) && state != SDO_PULSE)
      |-> STEP_PULSE_PIN_OUT == $past(step_inactive_pol, 1))
    else $error("step pin not at its idle level");

  step_active_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (state == SDO_PULSE && !$past(toggle_step, 1))
      |-> STEP_PULSE_PIN_OUT != $past(step_inactive_pol, 1))
    else $error("step pin not active during pulse");

  toggle_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (start_pulse && toggle_step) |=> $changed(STEP_PULSE_PIN_OUT))
    else $error("toggle mode missed a step edge");

  dir_pol_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    ##1 DIRECTION_PIN_OUT == (dir_neg ~^ $past(pol_dir_out, 1)))
    else $error("direction pin polarity wrong");

  pend_kept_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (pend && !start_pulse) |=> pend)
    else $error("held step request was dropped");

  ready_slot_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    !$past(SRST_IN, 1) |-> STEP_READY_OUT == !pend)
    else $error("ready does not match the request slot");

  hold_gap_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    dir_move_s |-> since_end >= {1'b0, step_width_extra_cycles})
    else $error("direction moved before the hold time ran out");

  dir_pin_still_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (state == SDO_PULSE && $past(pol_dir_out, 1) == $past(pol_dir_out, 2))
      |-> $stable(DIRECTION_PIN_OUT))
    else $error("direction pin moved during a step pulse");

  toggle_quiet_a: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    ($past(toggle_step, 1) && $past(toggle_step, 2) && !$past(start_pulse, 1))
      |-> $stable(STEP_PULSE_PIN_OUT))
    else $error("toggle step pin moved without a step");
endmodule // sdo_step_dir
`default_nettype wire

//--- verification/sdo_drv_model.sv
`timescale 1ns/10ps
`default_nettype none
// Driver side: counts steps, measures pulse width and set-up, counts direction moves inside a pulse or hold
module sdo_drv_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic idle_in,
  input wire logic toggle_in,
  output int steps,
  output int width,
  output int setup,
  output int dir_err
);
  logic step_q = 1'b0;
  logic dir_q = 1'b0;
  int run = 0;
  int since_dir = 0;
  int since_end = 999;
  logic dir_chg;
  logic was_on;
  assign dir_chg = dir_in !== dir_q;
  assign was_on = step_q !== idle_in;
  // Sample both pins each edge; reset clears the counts, but since_dir and since_end keep counting
  always @(posedge clk_in) begin
    step_q <= step_in;
    dir_q <= dir_in;
    since_dir <= dir_chg ? 0 : since_dir + 1;
    since_end <= (step_in === idle_in && was_on) ? 0 : since_end + 1;
    if (rst_in) begin
      steps <= 0;
      width <= 0;
      setup <= 0;
      dir_err <= 0;
      run <= 0;
    end else if (step_in !== step_q && (toggle_in || step_in !== idle_in)) begin
      steps <= steps + 1;
      setup <= since_dir;
      run <= 1;
    end else if (step_in !== idle_in) begin
      run <= run + 1;
    end
    if (!rst_in && !toggle_in && step_in === idle_in && was_on) begin
      width <= run;
    end
    // Direction moved inside a pulse or its hold window
    if (!rst_in && dir_chg && !toggle_in
        && (step_in !== idle_in || was_on || since_end < width - 1)) begin
      dir_err <= dir_err + 1;
    end
  end
endmodule // sdo_drv_model
`default_nettype wire

//--- verification/step_dir_output_stage_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module step_dir_output_stage_tb_top import sdo_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic neg = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [SDO_AW-1:0] addr = 7'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] got;
  logic ready;
  logic sp;
  logic dp;
  logic p;
  logic idle = 1'b0;
  logic tog = 1'b0;
  logic [15:0] x;
  logic [15:0] s;
  int steps;
  int width;
  int setup;
  int dir_err;
  int error_cnt = 0;
  int checks = 0;
  int n;
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  sdo_step_dir dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .STEP_REQ_IN(req), .STEP_NEG_IN(neg),
    .STEP_READY_OUT(ready), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .STEP_PULSE_PIN_OUT(sp), .DIRECTION_PIN_OUT(dp));
  sdo_drv_model drv (.clk_in(clk), .rst_in(srst), .step_in(sp), .dir_in(dp), .idle_in(idle),
    .toggle_in(tog), .steps(steps), .width(width), .setup(setup), .dir_err(dir_err));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask
  // One register cycle, read data kept in got
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = ~w;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    got = rdat;
  endtask
  // One step request once the slot is free
  task automatic step(input logic d);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk);
    req = 1'b1;
    neg = d;
    @(negedge clk);
    req = 1'b0;
  endtask
  // Poll status until idle with nothing pending
  task automatic settle();
    repeat (3) @(negedge clk);
    for (int i = 0; i < 100; i++) begin
      acc(1'b0, SDO_STATUS_ADDR, 32'h0);
      if (got[5] === 1'b0 && got[3:0] === 4'h1) break;
    end
  endtask
  // Verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(40 * 30000);
    error_cnt++;
    complete_run();
  end
  // Test sequence
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("step idle", 32'h0, 32'(sp));
    chk("dir idle", 32'h0, 32'(dp));
    chk("ready idle", 32'h1, 32'(ready));
    acc(1'b0, SDO_GLOBAL_CONFIG_ADDR, 32'h0);
    chk("config", {26'h0, SDO_CFG_RESET}, got);
    acc(1'b0, SDO_STEP_DIR_TIMING_ADDR, 32'h0);
    chk("timing", SDO_TIMING_RESET, got);
    acc(1'b0, 7'h05, 32'h0);
    chk("unmapped", 32'h0, got);
    $display("test reset done");
    // Width, set-up and queued steps for two timings
    for (int k = 0; k < 2; k++) begin
      x = 16'(3 * k);
      s = 16'(2 + 3 * k);
      acc(1'b1, SDO_STEP_DIR_TIMING_ADDR, {s, x});
      acc(1'b0, SDO_STEP_DIR_TIMING_ADDR, 32'h0);
      chk("timing rw", {s, x}, got);
      n = steps;
      step(1'b0);
      settle();
      chk("width", {16'h0, x} + 32'h1, 32'(width));
      chk("dir pos", 32'h0, 32'(dp));
      step(1'b1);
      settle();
      chk("dir neg", 32'h1, 32'(dp));
      chk("setup", {16'h0, s}, 32'(setup));
      step(1'b0);
      step(1'b1);
      chk("ready full", 32'h0, 32'(ready));
      settle();
      chk("steps", 32'(n + 4), 32'(steps));
      chk("setup queued", {16'h0, s}, 32'(setup));
    end
    chk("dir hold", 32'h0, 32'(dir_err));
    $display("test timing done");
    acc(1'b1, SDO_GLOBAL_CONFIG_ADDR, 32'hFFFF_FFC0);
    acc(1'b0, SDO_GLOBAL_CONFIG_ADDR, 32'h0);
    chk("config mask", 32'h0, got);
    chk("dir neg inv", 32'h0, 32'(dp));
    step(1'b0);
    settle();
    chk("dir pos inv", 32'h1, 32'(dp));
    idle = 1'b1;
    acc(1'b1, SDO_GLOBAL_CONFIG_ADDR, 32'h08);
    repeat (2) @(negedge clk);
    chk("step idle high", 32'h1, 32'(sp));
    n = steps;
    step(1'b0);
    settle();
    chk("low pulses", 32'(n + 1), 32'(steps));
    chk("low width", {16'h0, x} + 32'h1, 32'(width));
    $display("test polarity done");
    n = steps;
    tog = 1'b1;
    acc(1'b1, SDO_GLOBAL_CONFIG_ADDR, 32'h10);
    repeat (2) @(negedge clk);
    chk("toggle entry", 32'h1, 32'(sp));
    for (int k = 0; k < 2; k++) begin
      p = sp;
      step(1'b0);
      settle();
      chk("toggle level", {31'h0, ~p}, 32'(sp));
    end
    chk("toggle steps", 32'(n + 2), 32'(steps));
    $display("test toggle done");
    complete_run();
  end
endmodule // step_dir_output_stage_tb_top
`default_nettype wire
